//--- fe_model.sv
// converter source and downstream sink model for the y/c separator
`timescale 1ns/10ps
`default_nettype none

module fe_model
    import video_pkg::*;
(
    input wire logic core_clk,
    input wire logic in_ready,
    output logic [9:0] adc_luma_in,
    output logic [9:0] adc_chroma_in,
    output logic in_valid,
    input wire logic out_valid,
    output logic out_ready,
    input wire pix_t out_pix,
    input wire logic stall,
    output logic hang
);
    pix_t got[$];

    initial begin
        adc_luma_in = 10'h155;
        adc_chroma_in = 10'h2AA;
        in_valid = 1'b0;
        out_ready = 1'b0;
        hang = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // one converter sample, held until the edge that takes it
    task automatic put(input logic [9:0] a, input logic [9:0] b);
        int n;
        n = 0;
        @(negedge core_clk);
        in_valid = 1'b1;
        adc_luma_in = a;
        adc_chroma_in = b;
        @(posedge core_clk);
        while (!in_ready && n < 2000) begin
            n++;
            @(posedge core_clk);
        end
        if (n >= 2000) hang = 1'b1;
    endtask

    // two converter samples per pixel; component puts u first, then v
    task automatic pix(input logic [9:0] y0, input logic [9:0] y1,
                       input logic [9:0] c0, input logic [9:0] c1);
        put(y0, c0);
        put(y1, c1);
    endtask

    // released lines show the inverse, never the stale value
    task automatic idle();
        @(negedge core_clk);
        in_valid = 1'b0;
        adc_luma_in = ~adc_luma_in;
        adc_chroma_in = ~adc_chroma_in;
    endtask

    //////////////////////////////////////////////////////////////////////////
    always @(negedge core_clk) out_ready <= !stall;
    always @(posedge core_clk) if (out_valid && out_ready) got.push_back(out_pix);
endmodule

`default_nettype wire

//--- tb_video_yc_separator.sv
// self-checking testbench for the decimation and y/c separation datapath
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h expected %h", $time, g, e); end end

module tb_video_yc_separator
    import video_pkg::*;
;
    localparam int LL = 8;
    logic core_clk, rst, in_valid, in_ready, pal_equal, dec_bypass;
    logic comb_luma_bypass, comb_chroma_bypass, out_valid, out_ready, stall, hang;
    logic [9:0] adc_luma_in, adc_chroma_in;
    logic [1:0] notch_sel;
    src_mode_t src_mode;
    sep_mode_t sep_mode;
    pic_ctrl_t pic;
    pix_t out_pix;
    int n_errors = 0;
    int n_compared = 0;

    video_yc_separator #(.LINE_LEN(LL), .FIFO_DEPTH(8)) uut (.core_clk(core_clk), .rst(rst),
        .adc_luma_in(adc_luma_in), .adc_chroma_in(adc_chroma_in), .in_valid(in_valid),
        .in_ready(in_ready), .src_mode(src_mode), .sep_mode(sep_mode), .pal_equal(pal_equal),
        .dec_bypass(dec_bypass), .comb_luma_bypass(comb_luma_bypass),
        .comb_chroma_bypass(comb_chroma_bypass), .notch_sel(notch_sel), .pic(pic),
        .out_valid(out_valid), .out_ready(out_ready), .out_pix(out_pix));

    fe_model m (.core_clk(core_clk), .in_ready(in_ready), .adc_luma_in(adc_luma_in),
        .adc_chroma_in(adc_chroma_in), .in_valid(in_valid), .out_valid(out_valid),
        .out_ready(out_ready), .out_pix(out_pix), .stall(stall), .hang(hang));

    //////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic run(input int n, input logic [9:0] y0, input logic [9:0] y1,
                       input logic [9:0] c0, input logic [9:0] c1);
        m.got.delete();
        repeat (n) m.pix(y0, y1, c0, c1);
        m.idle();
        repeat (3) @(negedge core_clk);
        if (hang) begin
            n_errors++;
            end_of_test();
        end
    endtask

    // steady input: the newest output pixel must carry the settled value
    task automatic last_is(input logic [9:0] y, input logic [9:0] u, input logic [9:0] v);
        `CHK(m.got.size() > 0, 1'b1)
        if (m.got.size() > 0) begin
            `CHK(m.got[$].y, y)
            `CHK(m.got[$].u, u)
            `CHK(m.got[$].v, v)
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // hang guard
    initial begin
        #900000;
        n_errors++;
        end_of_test();
    end

    //////////////////////////////////////////////////////////////////////////
    initial begin
        int idx;
        int k;
        pix_t held;
        rst = 1'b1;
        src_mode = SRC_COMPONENT;
        sep_mode = SEP_ADAPT4;
        pal_equal = 1'b0;
        dec_bypass = 1'b1;
        comb_luma_bypass = 1'b0;
        comb_chroma_bypass = 1'b0;
        notch_sel = 2'h0;
        pic = '{contrast: 8'h80, brightness: 8'h80, saturation: 8'h80, hue: 8'h00};
        stall = 1'b0;
        repeat (5) @(negedge core_clk);
        `CHK(in_ready, 1'b1)
        `CHK(out_valid, 1'b0)
        `CHK(out_pix, 30'h0)
        rst = 1'b0;
        // component ramp: separation skipped, u/v demuxed and kept in step with y
        m.got.delete();
        repeat (20) m.pix(10'h040, 10'h040, 10'h200, 10'h200);
        for (k = 0; k < 24; k++) m.pix(10'h100 + 10'(8 * k), 10'h100 + 10'(8 * k),
                                      10'h180 + 10'(k), 10'h280 - 10'(k));
        repeat (20) m.pix(10'h040, 10'h040, 10'h200, 10'h200);
        m.idle();
        repeat (3) @(negedge core_clk);
        idx = -1;
        foreach (m.got[i]) if (idx < 0 && m.got[i].y === 10'h100) idx = i;
        `CHK(idx >= 0, 1'b1)
        for (k = 0; k < 24; k++) begin
            if (idx >= 0 && idx + k < m.got.size()) begin
                `CHK(m.got[idx + k].y, 10'h100 + 10'(8 * k))
                `CHK(m.got[idx + k].u, 10'h180 + 10'(k))
                `CHK(m.got[idx + k].v, 10'h280 - 10'(k))
            end
        end
        // saturation at zero flattens chroma
        pic.saturation = 8'h00;
        run(40, 10'h150, 10'h150, 10'h300, 10'h100);
        last_is(10'h150, 10'h200, 10'h200);
        pic.saturation = 8'h80;
        // half contrast and a small brightness lift on luma only
        pic.contrast = 8'h40;
        pic.brightness = 8'h90;
        run(40, 10'h150, 10'h150, 10'h300, 10'h100);
        last_is(10'h0B8, 10'h300, 10'h100);
        pic.contrast = 8'h80;
        pic.brightness = 8'h80;
        // alternating samples: half-band removes the top-of-band swing
        src_mode = SRC_SVIDEO;
        dec_bypass = 1'b0;
        run(40, 10'h280, 10'h2C0, 10'h200, 10'h200);
        last_is(10'h2A0, 10'h200, 10'h200);
        dec_bypass = 1'b1;
        run(40, 10'h280, 10'h2C0, 10'h200, 10'h200);
        `CHK(m.got[$].y === 10'h280 || m.got[$].y === 10'h2C0, 1'b1)
        // composite black-of-chroma level through every separator and notch setting
        src_mode = SRC_COMPOSITE;
        dec_bypass = 1'b0;
        for (k = 0; k < 16; k++) begin
            sep_mode = sep_mode_t'(k[3:2]);
            notch_sel = k[1:0];
            pal_equal = k[0];
            comb_luma_bypass = k[1];
            comb_chroma_bypass = k[2];
            run(40, 10'h200, 10'h200, 10'h155, 10'h155);
            last_is(10'h200, 10'h200, 10'h200);
        end
        // fill the output buffer against a stalled sink, then drain it
        src_mode = SRC_COMPONENT;
        stall = 1'b1;
        repeat (2) @(negedge core_clk);
        // re-test in_ready only after the edge that took the pixel has updated it
        for (k = 0; k < 40 && in_ready; k++) begin
            m.pix(10'h111, 10'h111, 10'h222, 10'h1DD);
            #1;
        end
        m.idle();
        @(negedge core_clk);
        `CHK(k, 8)
        `CHK(in_ready, 1'b0)
        `CHK(out_valid, 1'b1)
        held = out_pix;
        repeat (5) @(negedge core_clk);
        `CHK(out_pix, held)
        m.got.delete();
        stall = 1'b0;
        for (k = 0; k < 40 && (out_valid || m.got.size() == 0); k++) @(negedge core_clk);
        `CHK(m.got.size(), 8)
        `CHK(in_ready, 1'b1)
        `CHK(out_valid, 1'b0)
        `CHK(hang, 1'b0)
        end_of_test();
    end
endmodule

`default_nettype wire

//--- video_params.svh
// constants shared by the video decimation and y/c separation datapath
`ifndef VIDEO_PARAMS_SVH
`define VIDEO_PARAMS_SVH

`define VP_LINE_LEN 858
`define VP_FIFO_DEPTH 8
`define VP_LINE_TAPS 3
`define VP_MID 11'sh200
`define VP_BRI_MID 20'sh80
`define VP_GAIN_SH 7
`define VP_HB_SH 5
`define VP_ADAPT_TH 12'sh040
`define VP_CLIP_MAX 20'sh3FF

`endif

//--- video_pkg.sv
// types shared by the video decimation and y/c separation datapath
package video_pkg;

    typedef enum logic [1:0] {
        SRC_COMPOSITE = 2'b00,
        SRC_SVIDEO = 2'b01,
        SRC_COMPONENT = 2'b10
    } src_mode_t;

    typedef enum logic [1:0] {
        SEP_ADAPT4 = 2'b00,
        SEP_FIXED3 = 2'b01,
        SEP_FIXED2 = 2'b10,
        SEP_TRAP = 2'b11
    } sep_mode_t;

    typedef enum logic [1:0] {
        COMB_1331 = 2'b00,
        COMB_1111 = 2'b01,
        COMB_121 = 2'b10,
        COMB_11 = 2'b11
    } comb_kind_t;

    typedef struct packed {
        logic [1:0] ph;
        logic signed [10:0] c;
        logic signed [10:0] u;
        logic signed [10:0] v;
    } tap_t;

    typedef struct packed {
        logic [9:0] y;
        logic [9:0] u;
        logic [9:0] v;
    } pix_t;

    typedef struct packed {
        logic [7:0] contrast;
        logic [7:0] brightness;
        logic [7:0] saturation;
        logic [7:0] hue;
    } pic_ctrl_t;

endpackage

//--- video_yc_separator.sv
// decimation, quadrature demodulation, comb y/c separation and output fifo
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`include "video_params.svh"
`timescale 1ns/10ps
`default_nettype none

module yc_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = `VP_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, rp_q, wp_d, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic rdy_q, vld_q;
    logic [WIDTH-1:0] dat_q;

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    wire push = wr_valid & rdy_q;
    wire pop = vld_q & rd_ready;
    assign wp_d = push ? inc(wp_q) : wp_q;
    assign rp_d = pop ? inc(rp_q) : rp_q;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    // write into an empty fifo must reach the head register directly
    wire fall_thru = push && (rp_d == wp_q);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
            vld_q <= 1'b0;
            dat_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= cnt_d != (AW+1)'(DEPTH);
            vld_q <= cnt_d != '0;
            dat_q <= fall_thru ? wr_data : (cnt_d != '0) ? mem[rp_d] : dat_q;
        end
    end

    assign wr_ready = rdy_q;
    assign rd_valid = vld_q;
    assign rd_data = dat_q;
endmodule

//////////////////////////////////////////////////////////////////////////////
module video_yc_separator
    import video_pkg::*;
#(
    parameter int LINE_LEN = `VP_LINE_LEN,
    parameter int FIFO_DEPTH = `VP_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [9:0] adc_luma_in,
    input wire logic [9:0] adc_chroma_in,
    input wire logic in_valid,
    output logic in_ready,
    input wire src_mode_t src_mode,
    input wire sep_mode_t sep_mode,
    input wire logic pal_equal,
    input wire logic dec_bypass,
    input wire logic comb_luma_bypass,
    input wire logic comb_chroma_bypass,
    input wire logic [1:0] notch_sel,
    input wire pic_ctrl_t pic,
    output logic out_valid,
    input wire logic out_ready,
    output var pix_t out_pix
);
    localparam int LW = $clog2(LINE_LEN);
    function automatic logic [9:0] clip10(input logic signed [19:0] x);
        clip10 = (x < 0) ? 10'h000 : (x > `VP_CLIP_MAX) ? 10'h3FF : x[9:0];
    endfunction
    function automatic logic signed [19:0] halfband(input logic [6:0][9:0] w);
        logic [19:0] s;
        s = 20'h9 * (20'(w[2]) + 20'(w[4])) + (20'(w[3]) << 4) - 20'(w[0]) - 20'(w[6]);
        halfband = $signed(s) >>> `VP_HB_SH;
    endfunction
    function automatic logic signed [10:0] lpf(input logic signed [10:0] a,
        input logic signed [10:0] b, input logic signed [10:0] c,
        input logic signed [10:0] d, input logic [1:0] sel);
        logic signed [13:0] s;
        case (sel)
            2'h0: s = (14'(b) + 14'(c)) >>> 1;
            2'h1: s = (14'(a) + (14'(b) <<< 1) + 14'(c)) >>> 2;
            2'h2: s = (14'(a) + 14'(b) + 14'(c) + 14'(d)) >>> 2;
            default: s = (14'(a) + 14'sh3 * 14'(b) + 14'sh3 * 14'(c) + 14'(d)) >>> 3;
        endcase
        lpf = 11'(s);
    endfunction
    function automatic logic signed [10:0] comb(input logic signed [10:0] a,
        input logic signed [10:0] b, input logic signed [10:0] c,
        input logic signed [10:0] d, input comb_kind_t k);
        logic signed [13:0] s;
        case (k)
            COMB_1331: s = (14'(a) + 14'sh3 * 14'(b) + 14'sh3 * 14'(c) + 14'(d)) >>> 3;
            COMB_1111: s = (14'(a) + 14'(b) + 14'(c) + 14'(d)) >>> 2;
            COMB_121: s = (14'(a) + (14'(b) <<< 1) + 14'(c)) >>> 2;
            default: s = (14'(a) + 14'(b)) >>> 1;
        endcase
        comb = 11'(s);
    endfunction
    function automatic logic signed [12:0] remod(input tap_t t);
        case (t.ph)
            2'h0: remod = 13'(t.u) <<< 1;
            2'h1: remod = 13'(t.v) <<< 1;
            2'h2: remod = -(13'(t.u) <<< 1);
            default: remod = -(13'(t.v) <<< 1);
        endcase
    endfunction
    //////////////////////////////////////////////////////////////////////////
    logic phase_q;
    logic [6:0][9:0] la_q, lb_q;
    logic [9:0] x_q, c_q, cu_q, cv_q;
    logic [1:0] sc_q, ph_q;
    tap_t dw_q [4];
    tap_t lp_q, ch_q;
    tap_t t_q [4];
    tap_t tw_q [5];
    tap_t ud_q [2];
    tap_t line_rd [`VP_LINE_TAPS];
    logic [LW-1:0] wa_q;
    logic [1:0] lines_q;
    logic [5:0] vp_q;
    pix_t out_q;
    logic fifo_rdy;
    logic [$bits(pix_t)-1:0] fifo_rd;
    wire take = in_valid & fifo_rdy;
    wire pix_ev = take & phase_q;
    wire is_comp = src_mode == SRC_COMPOSITE;
    wire push = pix_ev & vp_q[5];
    // stage 1: decimate each pair of converter samples into one pixel
    wire signed [19:0] dec_a = dec_bypass ? $signed(20'(la_q[3])) : halfband(la_q);
    wire signed [19:0] dec_b = dec_bypass ? $signed(20'(lb_q[3])) : halfband(lb_q);
    // stage 2: demodulate; the fs/4 subcarrier model fixes the sampling ratio
    wire [9:0] dem_src = (src_mode == SRC_SVIDEO) ? c_q : x_q;
    wire signed [10:0] ds = $signed({1'b0, dem_src}) - `VP_MID;
    wire signed [10:0] dem_u = (ph_q == 2'h0) ? ds : (ph_q == 2'h2) ? -ds : '0;
    wire signed [10:0] dem_v = (ph_q == 2'h1) ? ds : (ph_q == 2'h3) ? -ds : '0;
    wire signed [10:0] cmp_u = $signed({1'b0, cu_q}) - `VP_MID;
    wire signed [10:0] cmp_v = $signed({1'b0, cv_q}) - `VP_MID;
    wire tap_t s2_tap = '{ph: ph_q, c: $signed({1'b0, x_q}) - `VP_MID,
        u: (src_mode == SRC_COMPONENT) ? cmp_u : dem_u,
        v: (src_mode == SRC_COMPONENT) ? cmp_v : dem_v};
    // stage 3: colour low-pass, component already baseband
    wire signed [10:0] lp_u = lpf(dw_q[0].u, dw_q[1].u, dw_q[2].u, dw_q[3].u, notch_sel);
    wire signed [10:0] lp_v = lpf(dw_q[0].v, dw_q[1].v, dw_q[2].v, dw_q[3].v, notch_sel);
    wire baseband = src_mode == SRC_COMPONENT;
    wire tap_t s3_tap = '{ph: dw_q[1].ph, c: dw_q[1].c,
        u: baseband ? dw_q[1].u : lp_u, v: baseband ? dw_q[1].v : lp_v};
    // stage 5: comb kind; adaptive falls back to 3-line across a vertical edge
    wire signed [11:0] edge_d = 12'(t_q[0].u) - 12'(t_q[3].u);
    wire adapt_edge = (edge_d > `VP_ADAPT_TH) || (edge_d < -`VP_ADAPT_TH);
    wire comb_kind_t kind = (sep_mode == SEP_FIXED2) ? COMB_11
        : (sep_mode == SEP_FIXED3 || adapt_edge) ? COMB_121
        : pal_equal ? COMB_1111 : COMB_1331;
    wire tap_t comb_tap = '{ph: t_q[1].ph, c: t_q[1].c,
        u: comb(t_q[0].u, t_q[1].u, t_q[2].u, t_q[3].u, kind),
        v: comb(t_q[0].v, t_q[1].v, t_q[2].v, t_q[3].v, kind)};
    // stage 6: luma selection and picture controls
    wire trap_luma = comb_luma_bypass || sep_mode == SEP_TRAP;
    wire raw_chroma = comb_chroma_bypass || sep_mode == SEP_TRAP || !is_comp;
    wire signed [12:0] rm = remod(ud_q[1]);
    wire signed [12:0] trap_y = (13'(tw_q[0].c) + (13'(tw_q[2].c) <<< 1) + 13'(tw_q[4].c)) >>> 2;
    wire signed [12:0] y_sel = !is_comp ? 13'(tw_q[2].c)
        : trap_luma ? trap_y : 13'(tw_q[2].c) - rm;
    wire tap_t uv_sel = raw_chroma ? tw_q[2] : ud_q[1];
    wire signed [19:0] yv = 20'(y_sel) + 20'(`VP_MID);
    wire signed [19:0] y_adj = ((yv * $signed({12'h0, pic.contrast})) >>> `VP_GAIN_SH)
        + $signed({12'h0, pic.brightness}) - `VP_BRI_MID;
    wire signed [19:0] sat = $signed({12'h0, pic.saturation});
    wire signed [19:0] u_adj = ((20'(uv_sel.u) * sat) >>> `VP_GAIN_SH) + 20'(`VP_MID);
    wire signed [19:0] v_adj = ((20'(uv_sel.v) * sat) >>> `VP_GAIN_SH) + 20'(`VP_MID);

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_q <= 1'b0;
            la_q <= '0;
            lb_q <= '0;
        end else if (take) begin
            phase_q <= ~phase_q;
            la_q <= {la_q[5:0], adc_luma_in};
            lb_q <= {lb_q[5:0], adc_chroma_in};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            x_q <= '0;
            c_q <= '0;
            cu_q <= '0;
            cv_q <= '0;
            sc_q <= '0;
            ph_q <= '0;
            vp_q <= '0;
        end else if (pix_ev) begin
            x_q <= clip10(dec_a);
            c_q <= clip10(dec_b);
            cu_q <= lb_q[4];
            cv_q <= lb_q[3];
            sc_q <= sc_q + 2'h1;
            ph_q <= sc_q + pic.hue[7:6];
            vp_q <= {vp_q[4:0], 1'b1};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dw_q <= '{default: '0};
            lp_q <= '0;
            t_q <= '{default: '0};
            ch_q <= '0;
            tw_q <= '{default: '0};
            ud_q <= '{default: '0};
            out_q <= '0;
        end else if (pix_ev) begin
            dw_q <= '{s2_tap, dw_q[0], dw_q[1], dw_q[2]};
            lp_q <= s3_tap;
            t_q <= '{lp_q, line_rd[0], line_rd[1], line_rd[2]};
            ch_q <= comb_tap;
            tw_q <= '{t_q[1], tw_q[0], tw_q[1], tw_q[2], tw_q[3]};
            ud_q <= '{ch_q, ud_q[0]};
            out_q <= '{y: clip10(y_adj), u: clip10(u_adj), v: clip10(v_adj)};
        end
    end

    // line write pointer; tap k reads zero until k+1 whole lines have been stored
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wa_q <= '0;
            lines_q <= '0;
        end else if (pix_ev) begin
            wa_q <= (wa_q == LW'(LINE_LEN - 1)) ? '0 : wa_q + LW'(1);
            if (wa_q == LW'(LINE_LEN - 1) && lines_q != 2'h3) begin
                lines_q <= lines_q + 2'h1;
            end
        end
    end

    for (genvar k = 0; k < `VP_LINE_TAPS; k++) begin : g_line
        tap_t mem [LINE_LEN];
        assign line_rd[k] = (lines_q > 2'(k)) ? mem[wa_q] : '0;
        if (k == 0) begin : g_first
            always_ff @(posedge core_clk) begin
                if (pix_ev) begin
                    mem[wa_q] <= lp_q;
                end
            end
        end else begin : g_next
            always_ff @(posedge core_clk) begin
                if (pix_ev) begin
                    mem[wa_q] <= line_rd[k-1];
                end
            end
        end
    end

    yc_fifo #(.WIDTH($bits(pix_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(core_clk),
        .rst(rst),
        .wr_valid(push),
        .wr_ready(fifo_rdy),
        .wr_data(out_q),
        .rd_valid(out_valid),
        .rd_ready(out_ready),
        .rd_data(fifo_rd)
    );
    assign in_ready = fifo_rdy;
    assign out_pix = pix_t'(fifo_rd);

    //////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_rate_half: assert property (pix_ev |=> !pix_ev)
        else $error("pixel event on two cycles in a row");
    a_dec_bypass: assert property (pix_ev && dec_bypass |=> x_q == $past(la_q[3]))
        else $error("bypassed decimation did not pass the raw sample");
    a_demod_null: assert property (pix_ev && is_comp && ph_q[0] |=> dw_q[0].u == '0)
        else $error("u demodulation not zero on a sine phase");
    a_complement: assert property (is_comp && !trap_luma |-> y_sel + rm == 13'(tw_q[2].c))
        else $error("luma plus remodulated chroma differs from composite");
    a_two_line: assert property (pix_ev && sep_mode == SEP_FIXED2 |=>
        ch_q.u == 11'((14'($past(t_q[0].u)) + 14'($past(t_q[1].u))) >>> 1))
        else $error("2-line comb is not an equal average");
    a_chroma_raw: assert property (raw_chroma |-> uv_sel.u == tw_q[2].u)
        else $error("bypassed chroma did not come from the delayed line");
    a_direct_y: assert property (!is_comp |-> y_sel == 13'(tw_q[2].c))
        else $error("s-video or component luma was separated");
    a_push_aligned: assert property (pix_ev && vp_q[5] && fifo_rdy |=> ##[0:1] out_valid)
        else $error("finished pixel did not reach the output fifo");
    c_fifo_full: cover property (in_valid && !fifo_rdy);
    c_adapt_edge: cover property (pix_ev && sep_mode == SEP_ADAPT4 && adapt_edge);
    c_out_taken: cover property (out_valid && out_ready);
endmodule
`default_nettype wire
